// ==== core/cws_top.sv ====
// control write sequencer with its control register bank, Avalon-MM slave
// assumes one 10 MHz clock, synchronous bus inputs, a master that holds its request
//
// Behaviour
// - width code 0..7 selects a written field of 1..8 bits.
// - four-bit field position gives the field lsb, bit 0 to 15.
// - each step holds an eight-bit target control register address.
// - end-of-step flag set halts after that step, otherwise advance.
// - step time including the write is unit times (2^delay + 8).
// - data bits above the field width are ignored.
// - writing one to cancel stops a running sequence at once.
// - writing one to go starts at the first step location.
// - steps run back to back without the host until the last one.
// - the go bit clears itself when the sequence finishes.
// - locations 0..31 are ram, 32..48 rom, 49..63 reserved.
// - read-only current index shows the most recently accessed location.
// - read-only running flag is one while a sequence executes.
// - host writes to control registers are refused while running.
// - step word writes are copied into ram at the program location.
// - the sequencer only starts while its enable bit is one.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module cws_top #(
    parameter int unsigned UNIT_CYCLES = cws_pkg::UNIT_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             sequencer_running_o
);
    // bus side
    logic        wait_ff;
    logic [31:0] readdata_ff;
    logic [7:0]  idx;
    logic        acc_wr;
    logic        is_seq_reg;
    logic [15:0] be_mask;
    logic [15:0] rd_word;
    logic [15:0] nxt_word;

    // sequencer registers
    logic        sequencer_on_ff;
    logic [4:0]  program_location_ff;
    logic [14:0] target_word_ff;
    logic [12:0] value_word_ff;
    logic [5:0]  first_step_location_ff;
    logic        sequence_go_ff;
    logic [5:0]  last_accessed_location_ff;
    logic        copy_ff;
    logic        running_ff;

    // step engine
    cws_pkg::cws_state_e state_ff;
    logic [5:0]  step_idx_ff;
    logic        eos_ff;
    logic [31:0] cnt_ff;
    logic [31:0] step_total;
    logic [5:0]  launch_idx;
    logic        cancel_req;
    logic        go_req;
    logic        start_ok;

    // current step fields
    logic [14:0] st_target;
    logic [12:0] st_value;
    logic [7:0]  target_reg_addr;
    logic [3:0]  field_lsb_position;
    logic [2:0]  field_width_code;
    logic [7:0]  step_value;
    logic [3:0]  step_wait_code;
    logic        last_step_flag;
    logic [15:0] merged;

    // the control register bank that steps and host both modify
    logic [15:0] ctrl_ff [256];

    // helpers read only by assertions
    logic [31:0] step_cyc_ff;
    logic [31:0] exp_cyc_ff;
    logic [7:0]  wmask;

    assign idx     = avs_address_i[9:2];
    assign acc_wr  = avs_write_i && !wait_ff;
    assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign is_seq_reg = (idx >= cws_pkg::IDX_ENABLE) && (idx <= cws_pkg::IDX_PROGRESS);

    assign {field_width_code, field_lsb_position, target_reg_addr} = st_target;
    assign {last_step_flag, step_wait_code, step_value}              = st_value;

    // step time in cycles: unit cycles times (2^code + 8)
    assign step_total = ((32'h1 << step_wait_code) + cws_pkg::EXTRA_UNITS) * UNIT_CYCLES;

    // launch register decode; the cancel bit works even while running
    assign cancel_req = acc_wr && (idx == cws_pkg::IDX_LAUNCH) && avs_byteenable_i[1]
                        && avs_writedata_i[cws_pkg::CANCEL_BIT];
    assign go_req     = acc_wr && (idx == cws_pkg::IDX_LAUNCH) && avs_byteenable_i[1]
                        && avs_writedata_i[cws_pkg::GO_BIT] && !cancel_req;
    assign launch_idx = avs_byteenable_i[0] ? avs_writedata_i[5:0] : first_step_location_ff;
    // reserved locations and a disabled sequencer never start
    assign start_ok   = go_req && sequencer_on_ff && (launch_idx <= cws_pkg::ROM_LAST)
                        && (state_ff == cws_pkg::CWS_IDLE);

    assign avs_readdata_o      = readdata_ff;
    assign avs_waitrequest_o   = wait_ff;
    assign sequencer_running_o = running_ff;

    cws_step_mem #(
        .STEPS       (cws_pkg::RAM_STEPS)
    ) u_mem (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .wr_en_i     (copy_ff),
        .wr_loc_i    (program_location_ff),
        .wr_target_i (target_word_ff),
        .wr_value_i  (value_word_ff),
        .rd_loc_i    (step_idx_ff),
        .rd_target_o (st_target),
        .rd_value_o  (st_value)
    );

    cws_field_merge u_merge (
        .old_i    (ctrl_ff[target_reg_addr]),
        .data_i   (step_value),
        .lsb_i    (field_lsb_position),
        .wcode_i  (field_width_code),
        .merged_o (merged)
    );

    // read mux: sequencer registers, else the control bank
    always_comb begin
        rd_word = 16'h0000;
        unique case (idx)
            cws_pkg::IDX_ENABLE:   rd_word = {7'h00, sequencer_on_ff, 3'h0, program_location_ff};
            cws_pkg::IDX_TARGET:   rd_word = {1'b0, target_word_ff};
            cws_pkg::IDX_VALUE:    rd_word = {1'b0, value_word_ff[12], 2'h0,
                                              value_word_ff[11:0]};
            cws_pkg::IDX_LAUNCH:   rd_word = {7'h00, sequence_go_ff, 2'h0, first_step_location_ff};
            cws_pkg::IDX_PROGRESS: rd_word = {6'h00, last_accessed_location_ff, 3'h0,
                                              running_ff};
            default:               rd_word = ctrl_ff[idx];
        endcase
        nxt_word = (rd_word & ~be_mask) | (avs_writedata_i[15:0] & be_mask);
    end

    // one wait cycle per request, then a single accept cycle
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wait_ff <= 1'b1;
        end else if (!wait_ff) begin
            wait_ff <= 1'b1;
        end else if (avs_read_i || avs_write_i) begin
            wait_ff <= 1'b0;
        end
    end

    // read data captured in the wait cycle and held through the accept edge
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            readdata_ff <= 32'h00000000;
        end else if (avs_read_i && wait_ff) begin
            readdata_ff <= {16'h0000, rd_word};
        end
    end

    // sequencer setup registers; host writes refused while running
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sequencer_on_ff        <= 1'b0;
            program_location_ff    <= 5'h00;
            target_word_ff         <= 15'h0000;
            value_word_ff          <= 13'h0000;
            first_step_location_ff <= 6'h00;
            copy_ff                <= 1'b0;
        end else begin
            copy_ff <= 1'b0;
            if (acc_wr && !running_ff) begin
                unique case (idx)
                    cws_pkg::IDX_ENABLE: begin
                        sequencer_on_ff     <= nxt_word[cws_pkg::ON_BIT];
                        program_location_ff <= nxt_word[4:0];
                    end
                    cws_pkg::IDX_TARGET: begin
                        target_word_ff <= nxt_word[14:0];
                        copy_ff        <= 1'b1;
                    end
                    cws_pkg::IDX_VALUE: begin
                        value_word_ff <= {nxt_word[cws_pkg::EOS_BIT], nxt_word[11:0]};
                        copy_ff       <= 1'b1;
                    end
                    cws_pkg::IDX_LAUNCH: begin
                        first_step_location_ff <= nxt_word[5:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // control bank: step writes while running, host writes only when idle
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 256; i++) begin
                ctrl_ff[i] <= cws_pkg::REG_RESET;
            end
        end else if (state_ff == cws_pkg::CWS_EXEC) begin
            ctrl_ff[target_reg_addr] <= merged;
        end else if (acc_wr && !running_ff && !is_seq_reg) begin
            ctrl_ff[idx] <= nxt_word;
        end
    end

    // step engine: one write cycle, then wait out the rest of the step time
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff                  <= cws_pkg::CWS_IDLE;
            step_idx_ff               <= 6'h00;
            eos_ff                    <= 1'b0;
            cnt_ff                    <= 32'h00000000;
            sequence_go_ff            <= 1'b0;
            running_ff                <= 1'b0;
            last_accessed_location_ff <= 6'h00;
        end else if (cancel_req) begin
            state_ff       <= cws_pkg::CWS_IDLE;
            sequence_go_ff <= 1'b0;
            running_ff     <= 1'b0;
        end else begin
            unique case (state_ff)
                cws_pkg::CWS_IDLE: begin
                    if (start_ok) begin
                        step_idx_ff    <= launch_idx;
                        state_ff       <= cws_pkg::CWS_EXEC;
                        sequence_go_ff <= 1'b1;
                        running_ff     <= 1'b1;
                    end
                end
                cws_pkg::CWS_EXEC: begin
                    last_accessed_location_ff <= step_idx_ff;
                    eos_ff   <= last_step_flag;
                    cnt_ff   <= step_total - 32'h2;
                    state_ff <= cws_pkg::CWS_WAIT;
                end
                cws_pkg::CWS_WAIT: begin
                    if (cnt_ff != 32'h0) begin
                        cnt_ff <= cnt_ff - 32'h1;
                    end else if (eos_ff || step_idx_ff == cws_pkg::ROM_LAST) begin
                        // the last rom entry also stops, so a run never enters reserved space
                        state_ff       <= cws_pkg::CWS_IDLE;
                        sequence_go_ff <= 1'b0;
                        running_ff     <= 1'b0;
                    end else begin
                        step_idx_ff <= step_idx_ff + 6'h1;
                        state_ff    <= cws_pkg::CWS_EXEC;
                    end
                end
            endcase
        end
    end

    // cycle count per step, seen only by the checks below
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            step_cyc_ff <= 32'h0;
            exp_cyc_ff  <= 32'h0;
        end else if (state_ff == cws_pkg::CWS_EXEC) begin
            step_cyc_ff <= 32'h1;
            exp_cyc_ff  <= step_total;
        end else begin
            step_cyc_ff <= step_cyc_ff + 32'h1;
        end
    end

    assign wmask = 8'((9'h002 << field_width_code) - 9'h001);

    a_go_starts: assert property (@(posedge clock_i) disable iff (reset_i)
        start_ok |=> running_ff && sequence_go_ff && step_idx_ff == $past(launch_idx))
        else $error("go did not start the sequence");

    a_cancel_stops: assert property (@(posedge clock_i) disable iff (reset_i)
        cancel_req |=> !running_ff && !sequence_go_ff && state_ff == cws_pkg::CWS_IDLE)
        else $error("cancel did not stop the sequence");

    a_refused_write: assert property (@(posedge clock_i) disable iff (reset_i)
        (acc_wr && running_ff && !is_seq_reg && state_ff == cws_pkg::CWS_WAIT)
        |=> ctrl_ff[$past(idx)] == $past(ctrl_ff[idx]))
        else $error("host write landed while running");

    a_step_time: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_WAIT && cnt_ff == 32'h0 && !cancel_req)
        |-> step_cyc_ff + 32'h1 == exp_cyc_ff)
        else $error("step time differs from the delay code");

    a_field_only: assert property (@(posedge clock_i) disable iff (reset_i)
        state_ff == cws_pkg::CWS_EXEC
        |-> ((merged ^ ctrl_ff[target_reg_addr]) & ~(16'(wmask) << field_lsb_position)) == 16'h0)
        else $error("bits outside the field changed");

    a_field_value: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_EXEC
         && ({1'b0, field_lsb_position} + {2'b0, field_width_code}) <= 5'h0f)
        |-> ((8'(merged >> field_lsb_position) & wmask) == (step_value & wmask)))
        else $error("field does not hold the step data");

    a_eos_halt: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_WAIT && cnt_ff == 32'h0 && eos_ff && !cancel_req)
        |=> state_ff == cws_pkg::CWS_IDLE && !sequence_go_ff && !running_ff)
        else $error("sequence did not halt on its last step");

    a_next_step: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_WAIT && cnt_ff == 32'h0 && !eos_ff && !cancel_req
         && step_idx_ff != cws_pkg::ROM_LAST)
        |=> state_ff == cws_pkg::CWS_EXEC && step_idx_ff == $past(step_idx_ff) + 6'h1)
        else $error("sequence did not advance");

    a_cur_index: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_EXEC && !cancel_req)
        |=> last_accessed_location_ff == $past(step_idx_ff))
        else $error("current index not updated");

    a_off_no_start: assert property (@(posedge clock_i) disable iff (reset_i)
        (!sequencer_on_ff && !running_ff) |=> !running_ff)
        else $error("disabled sequencer started");

    // reserved locations never start, and a run never walks past the rom
    a_reserved_idle: assert property (@(posedge clock_i) disable iff (reset_i)
        (go_req && launch_idx > cws_pkg::ROM_LAST && !running_ff) |=> !running_ff)
        else $error("reserved location started a sequence");

    a_rom_end_stop: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_ff == cws_pkg::CWS_WAIT && cnt_ff == 32'h0 && step_idx_ff == cws_pkg::ROM_LAST
         && !cancel_req) |=> state_ff == cws_pkg::CWS_IDLE && !running_ff)
        else $error("run went past the last rom location");

    a_go_self_clear: assert property (@(posedge clock_i) disable iff (reset_i)
        $fell(running_ff) |-> !sequence_go_ff)
        else $error("go bit still set after the run");

    // setup words must not move under a running sequence
    a_busy_setup: assert property (@(posedge clock_i) disable iff (reset_i)
        (acc_wr && running_ff && idx != cws_pkg::IDX_LAUNCH)
        |=> $stable(target_word_ff) && $stable(value_word_ff)
            && $stable(sequencer_on_ff) && $stable(program_location_ff))
        else $error("setup register changed while running");

    a_ram_copy: assert property (@(posedge clock_i) disable iff (reset_i)
        copy_ff |=> u_mem.ram_ff[$past(program_location_ff)]
                    == {$past(target_word_ff), $past(value_word_ff)})
        else $error("step words not copied into ram");
endmodule

// ==== core/cws_pkg.sv ====
// constants, field layouts and types of the control write sequencer
// assumes a 10 MHz clock and 16-bit control registers on a word-per-register bus
package cws_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_ENABLE   = 8'h6c;
    localparam logic [7:0] IDX_TARGET   = 8'h6d;
    localparam logic [7:0] IDX_VALUE    = 8'h6e;
    localparam logic [7:0] IDX_LAUNCH   = 8'h6f;
    localparam logic [7:0] IDX_PROGRESS = 8'h70;
    localparam logic [15:0] REG_RESET   = 16'h0000;

    // bit positions inside the registers
    localparam int ON_BIT     = 8;
    localparam int CANCEL_BIT = 9;
    localparam int GO_BIT     = 8;
    localparam int EOS_BIT    = 14;
    localparam int BUSY_BIT   = 0;
    localparam int CUR_LSB    = 4;
    localparam int WCODE_LSB  = 12;
    localparam int FPOS_LSB   = 8;
    localparam int DELAY_LSB  = 8;

    // step memory map
    localparam int         RAM_STEPS  = 32;
    localparam logic [5:0] ROM_FIRST  = 6'h20;
    localparam logic [5:0] ROM_LAST   = 6'h30;
    localparam logic [7:0] ROM_TARGET = 8'h20;  // preset target register

    // step timing: unit time per step and the fixed extra units
    localparam real STEP_UNIT_US  = 62.5;
    localparam real CLK_PERIOD_NS = 100.0;
    localparam int  UNIT_CYCLES   = int'(STEP_UNIT_US * 1000.0 / CLK_PERIOD_NS);
    localparam logic [31:0] EXTRA_UNITS = 32'h8;

    typedef enum logic [1:0] {
        CWS_IDLE,
        CWS_EXEC,
        CWS_WAIT
    } cws_state_e;
endpackage

// ==== core/cws_step_mem.sv ====
// step memory: writable ram steps followed by fixed preset rom steps
// assumes the caller never writes while reading the same ram entry matters
`timescale 1ns/1ps
module cws_step_mem #(
    parameter int STEPS = 32
) (
    input  wire logic                     clock_i,
    input  wire logic                     reset_i,
    input  wire logic                     wr_en_i,
    input  wire logic [$clog2(STEPS)-1:0] wr_loc_i,
    input  wire logic [14:0]              wr_target_i,
    input  wire logic [12:0]              wr_value_i,
    input  wire logic [5:0]               rd_loc_i,
    output logic      [14:0]              rd_target_o,
    output logic      [12:0]              rd_value_o
);
    logic [27:0] ram_ff [STEPS];
    logic [5:0]  rom_off;

    // ram copy of host-programmed steps
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < STEPS; i++) begin
                ram_ff[i] <= 28'h0000000;
            end
        end else if (wr_en_i) begin
            ram_ff[wr_loc_i] <= {wr_target_i, wr_value_i};
        end
    end

    // rom presets are fixed: each sets one bit, the last ends the run
    always_comb begin
        rom_off = rd_loc_i - cws_pkg::ROM_FIRST;
        if (rd_loc_i < cws_pkg::ROM_FIRST) begin
            {rd_target_o, rd_value_o} = ram_ff[rd_loc_i[$clog2(STEPS)-1:0]];
        end else begin
            rd_target_o = {3'h0, rom_off[3:0], cws_pkg::ROM_TARGET};
            rd_value_o  = {rd_loc_i >= cws_pkg::ROM_LAST, 4'h0, 8'h01};
        end
    end
endmodule

// ==== core/cws_field_merge.sv ====
// replaces one bit field of a 16-bit register value with step data
// purely combinational; field bits past bit 15 simply fall off
`timescale 1ns/1ps
module cws_field_merge (
    input  wire logic [15:0] old_i,
    input  wire logic [7:0]  data_i,
    input  wire logic [3:0]  lsb_i,
    input  wire logic [2:0]  wcode_i,
    output logic      [15:0] merged_o
);
    logic [23:0] mask24;
    logic [23:0] data24;

    // width code n selects n+1 bits; surplus data msbs are masked off
    always_comb begin
        mask24   = ((24'h000001 << ({1'b0, wcode_i} + 4'h1)) - 24'h000001) << lsb_i;
        data24   = {16'h0000, data_i} << lsb_i;
        merged_o = (old_i & ~mask24[15:0]) | (data24[15:0] & mask24[15:0]);
    end
endmodule

// ==== sim/cws_host.sv ====
// host model: avalon-mm master issuing one word transfer at a time
// assumes a slave that drops waitrequest for one accept cycle per request; waits as long as needed
`timescale 1ns/1ps
module cws_host (
    input  wire logic        clock_i,
    input  wire logic        avs_waitrequest_i,
    input  wire logic [31:0] avs_readdata_i,
    output logic      [9:0]  avs_address_o,
    output logic             avs_read_o,
    output logic             avs_write_o,
    output logic      [31:0] avs_writedata_o,
    output logic      [3:0]  avs_byteenable_o
);
    // idle bus at time zero
    initial begin
        avs_address_o    = 10'h3ff;
        avs_read_o       = 1'b0;
        avs_write_o      = 1'b0;
        avs_writedata_o  = 32'hffffffff;
        avs_byteenable_o = 4'h0;
    end

    // request held until waitrequest is sampled low, then released at that edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d,
                        input logic [3:0] be, output logic [15:0] q);
        @(posedge clock_i);
        avs_address_o    <= {idx, 2'b00};
        avs_read_o       <= ~w;
        avs_write_o      <= w; // never both high
        avs_writedata_o  <= {16'h0000, d};
        avs_byteenable_o <= be;
        // only the bench timeout ends a stalled wait
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest_i !== 1'b0);
        q = avs_readdata_i[15:0];
        avs_read_o       <= 1'b0;
        avs_write_o      <= 1'b0;
        // stale lines show their inverse so a late sample cannot match by luck
        avs_address_o    <= ~avs_address_o;
        avs_writedata_o  <= ~avs_writedata_o;
    endtask
endmodule

// ==== sim/test_control_write_sequencer.sv ====
// bench for the sequencer: host model on the bus, integer model of the register bank
// assumes UNIT_CYCLES shortened to 2 so whole sequences run in a few hundred cycles
`timescale 1ns/1ps
module test_control_write_sequencer;
    localparam int UNIT = 2;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [9:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        running;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          bank [256];

    always #50 clock_i = ~clock_i;

    cws_top #(.UNIT_CYCLES(UNIT)) DUT (
        .clock_i(clock_i), .reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .sequencer_running_o(running)
    );
    cws_host host (
        .clock_i(clock_i), .avs_waitrequest_i(waitreq), .avs_readdata_i(rdata),
        .avs_address_o(addr), .avs_read_o(rd_en), .avs_write_o(wr_en),
        .avs_writedata_o(wdata), .avs_byteenable_o(be)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // cycle count for step timing; also cuts a hang short
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [15:0] q;
        host.xfer(1'b1, idx, d, 4'h3, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] e);
        logic [15:0] q;
        host.xfer(1'b0, idx, 16'h0000, 4'h3, q);
        chk(q, e);
    endtask
    // model of one step: field of width code+1 at lsb, surplus data bits dropped
    function automatic int merge(int old, int tgt, int val);
        int w;
        int m;
        w = ((tgt >> 12) & 7) + 1;
        m = (((1 << w) - 1) << ((tgt >> 8) & 15)) & 32'hffff;
        return (old & ~m) | (((val & 32'hff) << ((tgt >> 8) & 15)) & m);
    endfunction
    function automatic int steptime(int val);
        return ((1 << ((val >> 8) & 15)) + 8) * UNIT;
    endfunction
    // waits for the run to end; t is the cycle count at the go accept edge
    task automatic wait_end(input int t, input int exp);
        while (running === 1'b1 && cyc - t < 40000) @(posedge clock_i);
        chk(16'(cyc - t - 1), 16'(exp));
    endtask

    initial begin
        int t;
        int tg [2];
        int vl [2];
        logic [15:0] q;
        void'($urandom(32'ha04d5832));
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(cws_pkg::IDX_PROGRESS, 16'h0000);
        rd(cws_pkg::IDX_LAUNCH, 16'h0000);
        // plain control registers, then one low-lane write
        for (int i = 0; i < 8; i++) begin
            bank[16 + i] = $urandom & 32'hffff;
            wr(8'(16 + i), 16'(bank[16 + i]));
        end
        host.xfer(1'b1, 8'h18, 16'habcd, 4'h1, q);
        bank[24] = 32'h00cd;
        for (int i = 0; i < 9; i++) rd(8'(16 + i), 16'(bank[16 + i]));
        // two ram steps at the top of ram: clean data, then junk above the field
        tg[0] = ($urandom & 32'h7f00) | 32'h40;
        vl[0] = ($urandom & 32'h0300) | ($urandom & ((2 << ((tg[0] >> 12) & 7)) - 1));
        tg[1] = ($urandom & 32'h7f00) | 32'h41;
        vl[1] = 32'h4000 | ($urandom & 32'h03ff);
        for (int s = 0; s < 2; s++) begin
            wr(cws_pkg::IDX_ENABLE, 16'(32'h0100 | (30 + s)));
            wr(cws_pkg::IDX_TARGET, 16'(tg[s]));
            wr(cws_pkg::IDX_VALUE, 16'(vl[s]));
            bank[64 + s] = merge(0, tg[s], vl[s]);
        end
        wr(cws_pkg::IDX_LAUNCH, 16'h011e);
        t = cyc;
        wr(8'h10, ~16'(bank[16]));
        chk(16'(running), 16'h0001);
        rd(cws_pkg::IDX_PROGRESS, 16'h01e1);
        wait_end(t, steptime(vl[0]) + steptime(vl[1]));
        rd(cws_pkg::IDX_LAUNCH, 16'h001e);
        rd(cws_pkg::IDX_PROGRESS, 16'h01f0);
        rd(8'h40, 16'(bank[64]));
        rd(8'h41, 16'(bank[65]));
        rd(8'h10, 16'(bank[16]));
        // long step, cancelled a few cycles in
        wr(cws_pkg::IDX_ENABLE, 16'h0100);
        wr(cws_pkg::IDX_TARGET, 16'h0042);
        wr(cws_pkg::IDX_VALUE, 16'h0a00);
        wr(cws_pkg::IDX_LAUNCH, 16'h0100);
        repeat (5) @(posedge clock_i);
        wr(cws_pkg::IDX_LAUNCH, 16'h0200);
        @(posedge clock_i);
        chk(16'(running), 16'h0000);
        rd(cws_pkg::IDX_PROGRESS, 16'h0000);
        bank[16] = $urandom & 32'hffff;
        wr(8'h10, 16'(bank[16]));
        rd(8'h10, 16'(bank[16]));
        // whole preset sequence from the first rom location
        wr(cws_pkg::IDX_LAUNCH, 16'h0120);
        t = cyc;
        @(posedge clock_i);
        wait_end(t, 17 * 9 * UNIT);
        rd(8'h20, 16'hffff);
        rd(cws_pkg::IDX_PROGRESS, 16'h0300);
        // go ignored with the sequencer off or with a reserved location
        for (int k = 0; k < 2; k++) begin
            wr(cws_pkg::IDX_ENABLE, 16'(k * 32'h0100));
            wr(cws_pkg::IDX_LAUNCH, 16'(32'h0100 | (k * 49)));
            @(posedge clock_i);
            @(posedge clock_i);
            chk(16'(running), 16'h0000);
            rd(cws_pkg::IDX_LAUNCH, 16'(k * 49));
        end
        end_sim();
    end
endmodule
